/* drs_pkg.sv */
// package: constants, address map and types of the dual radio reset sequencer
`default_nettype none
package drs_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RST_PULSE_NS = 1000;
  localparam int POWERUP_NS = 2000;
  localparam int CHIP_RESET_NS = 1000;
  localparam int TRX_RESET_NS = 500;
  // all are least times, so round up to whole cycles
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHIP_RESET_CYC = (CHIP_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRX_RESET_CYC = (TRX_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // ==========================================================
  // address map (14-bit control port address space)
  localparam logic [13:0] ADDR_CHIP_RESET = 14'h0005;
  localparam logic [13:0] ADDR_CFG = 14'h0006;
  localparam logic [13:0] ADDR_CLOCK_OUT_PIN = 14'h0007;
  localparam logic [13:0] ADDR_IQ_A = 14'h000A;
  localparam logic [13:0] ADDR_IQ_B = 14'h000B;
  localparam logic [5:0] TRX_PAGE0 = 6'h01;
  localparam logic [7:0] TRX_OFS_IRQ = 8'h00;
  localparam logic [7:0] TRX_OFS_CMD = 8'h02;
  localparam logic [3:0] TRX_BANK_NIB = 4'h1;
  localparam int TRX_BANK_DEPTH = 16;
  localparam int TRX_BANK_AW = 4;

  // ==========================================================
  // fields and reset values
  localparam int CMD_MSB = 2;
  localparam logic [2:0] CHIP_RESET_CODE = 3'h7;
  localparam logic [2:0] CHIP_RESET_INIT = 3'h0;
  localparam logic [7:0] CFG_INIT = 8'h09;
  localparam int CFG_IRQ_POLARITY_BIT_BIT = 2;
  localparam logic [7:0] CLOCK_OUT_PIN_INIT = 8'h01;
  localparam int CLOCK_OUT_PIN_RATE_MSB = 2;
  localparam logic [7:0] IQ_INIT = 8'h00;
  localparam logic [7:0] RADIO_CMD_RESET = 8'h07;
  localparam logic [7:0] RADIO_CMD_INIT = 8'h00;
  localparam logic [7:0] BANK_INIT = 8'h00;
  localparam int SPI_MODE_WR_BIT = 15;
  localparam int SPI_MODE_RSV_BIT = 14;
  // synchroniser idle levels: {supply_ok, ext_reset_n, sclk, seln_n, mosi}
  localparam logic [4:0] SYNC_INIT = 5'h0A;
  localparam int GRP_COMMON = 0;
  localparam int GRP_IQ = 1;
  localparam int GRP_TRX0 = 2;

  typedef enum logic [3:0] {
    SEQ_OFF = 4'b0001,
    SEQ_POWERUP = 4'b0010,
    SEQ_RESET = 4'b0100,
    SEQ_IDLE = 4'b1000
  } drs_seq_t;
endpackage
`default_nettype wire

/* drs_reg_bank.sv */
// module: per-transceiver register bank with group clear and registered read
`default_nettype none
module drs_reg_bank
  import drs_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int DW = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem [DEPTH];

  // ==========================================================
  // storage: clear beats a write in the same cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= DW'(BANK_INIT);
      end
    end else if (clear_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= DW'(BANK_INIT);
      end
    end else if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule
`default_nettype wire

/* drs_sequencer.sv */
// module: reset, power-up and wake sequencing with control port register access
`default_nettype none

// Notes on behaviour
// - Low pulse on ext_reset_n of at least minimum width starts chip reset at release.
// - Writing 0x07 to the chip reset command field starts chip reset.
// - Chip reset returns both radios, basebands and every register to defaults.
// - Chip reset passes through an internal reset state, then lands in idle.
// - Chip reset completion raises wake_done_flag for both transceivers.
// - Transceiver reset command clears only that transceiver; common registers stay.
// - Transceiver reset ends in idle with wake_done_flag for that transceiver only.
// - Register groups are cleared per reset source, including both sleep kinds.
// - Supply dropping out and returning causes a full power-on reset.
// - Power-up enables oscillator and regulator, clock out at default rate, defaults.
// - Control port is ignored until the idle state is reached.
// - Reaching idle after power-up sets both wake flags and drives interrupt high.
// - Chip reset register at 0x0005: bits 7..3 read zero, bits 2..0 read-write.
// - One interrupt output serves both transceivers; host reads status to find cause.
// - Command field values 0 to 6 have no effect; only 7 resets.
// - After a chip reset or power-on reset the interrupt polarity defaults to active high.
module drs_sequencer
  import drs_pkg::*;
#(
  parameter int RST_PULSE_CYCLES = RST_PULSE_CYC,
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int CHIP_RESET_CYCLES = CHIP_RESET_CYC,
  parameter int TRX_RESET_CYCLES = TRX_RESET_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic supply_ok_i,
  input wire logic ext_reset_n_i,
  input wire logic sclk_i,
  input wire logic seln_n_i,
  input wire logic mosi_i,
  input wire logic deep_sleep_i,
  input wire logic [1:0] trx_sleep_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  output logic irq_o,
  output logic osc_en_o,
  output logic dreg_en_o,
  output logic clock_out_en_o,
  output logic [2:0] clock_out_rate_o,
  output logic [1:0] radio_idle_o,
  output logic [3:0] group_clear_o,
  output logic [7:0] iq_link_config_a_o,
  output logic [7:0] iq_link_config_b_o
);

  // ==========================================================
  // input synchronisers
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic sclk_prev;
  logic pin_prev;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a <= SYNC_INIT;
      sync_b <= SYNC_INIT;
      sclk_prev <= 1'b0;
      pin_prev <= 1'b1;
    end else begin
      sync_a <= {supply_ok_i, ext_reset_n_i, sclk_i, seln_n_i, mosi_i};
      sync_b <= sync_a;
      sclk_prev <= sync_b[2];
      pin_prev <= sync_b[3];
    end
  end

  wire sup_ok = sync_b[4];
  wire pin_n = sync_b[3];
  wire sclk_s = sync_b[2];
  wire seln_s = sync_b[1];
  wire mosi_s = sync_b[0];
  wire sclk_rise = sclk_s & ~sclk_prev;
  wire sclk_fall = ~sclk_s & sclk_prev;

  // ==========================================================
  // reset pin pulse width check
  logic [CNT_W-1:0] pin_low_cnt;
  wire pin_full = (pin_low_cnt == CNT_W'(RST_PULSE_CYCLES));
  wire pin_trig = pin_n & ~pin_prev & pin_full;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_low_cnt <= '0;
    end else if (pin_n) begin
      pin_low_cnt <= pin_prev ? '0 : pin_low_cnt;
    end else if (!pin_full) begin
      pin_low_cnt <= pin_low_cnt + 1'b1;
    end
  end

  // ==========================================================
  // chip sequencer
  drs_seq_t state;
  drs_seq_t next_state;
  logic [CNT_W-1:0] seq_cnt;
  logic [CNT_W-1:0] next_cnt;
  logic wr_stb;
  logic cmd_trig;
  wire chip_trig = pin_trig | cmd_trig;
  wire pow_end = (seq_cnt == CNT_W'(POWERUP_CYCLES - 1));
  wire rst_end = (seq_cnt == CNT_W'(CHIP_RESET_CYCLES - 1));
  wire seq_idle = (state == SEQ_IDLE);
  wire seq_done = ~seq_idle & (next_state == SEQ_IDLE);
  wire chip_clear = ~seq_idle;

  always_comb begin
    next_state = state;
    next_cnt = seq_cnt + 1'b1;
    case (state)
      SEQ_OFF: begin
        next_cnt = '0;
        if (sup_ok) begin
          next_state = SEQ_POWERUP;
        end
      end
      SEQ_POWERUP: begin
        if (pow_end) begin
          next_state = SEQ_IDLE;
          next_cnt = '0;
        end
      end
      SEQ_RESET: begin
        if (chip_trig) begin
          next_cnt = '0;
        end else if (rst_end) begin
          next_state = SEQ_IDLE;
          next_cnt = '0;
        end
      end
      SEQ_IDLE: begin
        next_cnt = '0;
        if (chip_trig) begin
          next_state = SEQ_RESET;
        end
      end
      default: begin
        next_state = SEQ_OFF;
        next_cnt = '0;
      end
    endcase
    if (!sup_ok) begin
      next_state = SEQ_OFF;
      next_cnt = '0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= SEQ_OFF;
      seq_cnt <= '0;
    end else begin
      state <= next_state;
      seq_cnt <= next_cnt;
    end
  end

  // ==========================================================
  // control port: byte-wise, two command bytes, then data with address increment
  logic [3:0] bit_cnt;
  logic cmd_done;
  logic mode_wr;
  logic mode_ok;
  logic [15:0] rx_shift;
  logic [13:0] acc_addr;
  logic rd_stb;
  logic load_pending;
  logic [6:0] tx_shift;
  wire spi_active = ~seln_s & seq_idle;
  wire [15:0] rx_word = {rx_shift[14:0], mosi_s};
  wire cmd_end = spi_active & sclk_rise & ~cmd_done & (bit_cnt == 4'hF);
  wire data_end = spi_active & sclk_rise & cmd_done & (bit_cnt[2:0] == 3'h7);
  wire word_ok = ~rx_word[SPI_MODE_RSV_BIT];
  assign wr_stb = data_end & mode_wr & mode_ok;
  wire [7:0] wr_data = rx_word[7:0];
  wire tx_load = spi_active & sclk_fall & load_pending;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt <= '0;
      cmd_done <= 1'b0;
      mode_wr <= 1'b0;
      mode_ok <= 1'b0;
      rx_shift <= '0;
      acc_addr <= '0;
    end else if (!spi_active) begin
      bit_cnt <= '0;
      cmd_done <= 1'b0;
    end else if (sclk_rise) begin
      rx_shift <= rx_word;
      bit_cnt <= bit_cnt + 1'b1;
      if (cmd_end) begin
        cmd_done <= 1'b1;
        mode_wr <= rx_word[SPI_MODE_WR_BIT];
        mode_ok <= word_ok;
        acc_addr <= rx_word[13:0];
      end else if (data_end) begin
        acc_addr <= acc_addr + 1'b1;
      end
    end
  end

  // the bank reads acc_addr every cycle, so data are ready one cycle after rd_stb
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_stb <= 1'b0;
      load_pending <= 1'b0;
    end else begin
      rd_stb <= (cmd_end & ~rx_word[SPI_MODE_WR_BIT] & word_ok) |
                (data_end & ~mode_wr & mode_ok);
      if (!spi_active || tx_load) begin
        load_pending <= 1'b0;
      end else if (rd_stb) begin
        load_pending <= 1'b1;
      end
    end
  end

  // ==========================================================
  // address decode
  function automatic logic in_bank(input logic [7:0] ofs);
    in_bank = (ofs[7:4] == TRX_BANK_NIB);
  endfunction

  wire hit_rst = (acc_addr == ADDR_CHIP_RESET);
  wire hit_cfg = (acc_addr == ADDR_CFG);
  wire hit_clock_out_pin = (acc_addr == ADDR_CLOCK_OUT_PIN);
  wire hit_iqa = (acc_addr == ADDR_IQ_A);
  wire hit_iqb = (acc_addr == ADDR_IQ_B);
  assign cmd_trig = wr_stb & hit_rst & (wr_data[CMD_MSB:0] == CHIP_RESET_CODE);

  // ==========================================================
  // common and I/Q registers
  logic [2:0] chip_rst_cmd;
  logic [7:0] cfg;
  logic [7:0] clock_out_pin_cfg;
  wire clr_common = chip_clear;
  wire clr_iq = chip_clear | deep_sleep_i;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      chip_rst_cmd <= CHIP_RESET_INIT;
      cfg <= CFG_INIT;
      clock_out_pin_cfg <= CLOCK_OUT_PIN_INIT;
    end else if (clr_common) begin
      chip_rst_cmd <= CHIP_RESET_INIT;
      cfg <= CFG_INIT;
      clock_out_pin_cfg <= CLOCK_OUT_PIN_INIT;
    end else if (wr_stb) begin
      if (hit_rst) begin
        chip_rst_cmd <= wr_data[CMD_MSB:0];
      end
      if (hit_cfg) begin
        cfg <= {4'h0, wr_data[3:0]};
      end
      if (hit_clock_out_pin) begin
        clock_out_pin_cfg <= wr_data;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      iq_link_config_a_o <= IQ_INIT;
      iq_link_config_b_o <= IQ_INIT;
    end else if (clr_iq) begin
      iq_link_config_a_o <= IQ_INIT;
      iq_link_config_b_o <= IQ_INIT;
    end else if (wr_stb && hit_iqa) begin
      iq_link_config_a_o <= wr_data;
    end else if (wr_stb && hit_iqb) begin
      iq_link_config_b_o <= wr_data;
    end
  end

  // ==========================================================
  // per-transceiver reset, status flag and register group
  logic [1:0] trx_busy;
  logic [1:0] wake_flag;
  logic [1:0] clr_trx;
  logic [7:0] trx_rd [2];

  for (genvar n = 0; n < 2; n++) begin : g_trx
    logic [CNT_W-1:0] trx_cnt;
    logic [7:0] radio_cmd;
    logic [7:0] bank_rd;
    wire sel = (acc_addr[13:8] == TRX_PAGE0 + 6'(n));
    wire hit_irq = sel & (acc_addr[7:0] == TRX_OFS_IRQ);
    wire hit_cmd = sel & (acc_addr[7:0] == TRX_OFS_CMD);
    wire hit_bank = sel & in_bank(acc_addr[7:0]);
    wire trx_trig = wr_stb & hit_cmd & (wr_data == RADIO_CMD_RESET);
    wire trx_done = trx_busy[n] & (trx_cnt == CNT_W'(TRX_RESET_CYCLES - 1));
    wire wake_set = seq_done | trx_done;
    wire rd_clear = tx_load & hit_irq;
    assign clr_trx[n] = chip_clear | deep_sleep_i | trx_sleep_i[n] | trx_busy[n];

    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        trx_busy[n] <= 1'b0;
        trx_cnt <= '0;
      end else if (chip_clear) begin
        trx_busy[n] <= 1'b0;
        trx_cnt <= '0;
      end else if (trx_trig) begin
        trx_busy[n] <= 1'b1;
        trx_cnt <= '0;
      end else if (trx_done) begin
        trx_busy[n] <= 1'b0;
      end else if (trx_busy[n]) begin
        trx_cnt <= trx_cnt + 1'b1;
      end
    end

    // set wins over both the group clear and the clear on read
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        wake_flag[n] <= 1'b0;
      end else if (wake_set) begin
        wake_flag[n] <= 1'b1;
      end else if (clr_trx[n] || rd_clear) begin
        wake_flag[n] <= 1'b0;
      end
    end

    // the reset code is stored, then wiped by the clear that it starts
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        radio_cmd <= RADIO_CMD_INIT;
      end else if (clr_trx[n]) begin
        radio_cmd <= RADIO_CMD_INIT;
      end else if (wr_stb && hit_cmd) begin
        radio_cmd <= wr_data;
      end
    end

    drs_reg_bank #(
      .DEPTH(TRX_BANK_DEPTH),
      .AW(TRX_BANK_AW),
      .DW(8)
    ) u_bank (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .clear_i(clr_trx[n]),
      .wr_en_i(wr_stb & hit_bank),
      .wr_addr_i(acc_addr[TRX_BANK_AW-1:0]),
      .wr_data_i(wr_data),
      .rd_addr_i(acc_addr[TRX_BANK_AW-1:0]),
      .rd_data_o(bank_rd)
    );

    assign trx_rd[n] = ({8{hit_irq}} & {7'h00, wake_flag[n]}) |
                       ({8{hit_cmd}} & radio_cmd) |
                       ({8{hit_bank}} & bank_rd);
  end

  // ==========================================================
  // read data select; unmapped addresses read as zero
  wire [7:0] rd_word = ({8{hit_rst}} & {5'h00, chip_rst_cmd}) |
                       ({8{hit_cfg}} & cfg) |
                       ({8{hit_clock_out_pin}} & clock_out_pin_cfg) |
                       ({8{hit_iqa}} & iq_link_config_a_o) |
                       ({8{hit_iqb}} & iq_link_config_b_o) |
                       trx_rd[0] | trx_rd[1];

  // while selected, miso changes only on the falling edge of sclk, msb first; deselected it is held low
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      miso_o <= 1'b0;
      tx_shift <= '0;
      miso_oe_n_o <= 1'b1;
    end else begin
      miso_oe_n_o <= ~spi_active;
      if (!spi_active) begin
        miso_o <= 1'b0;
        tx_shift <= '0;
      end else if (tx_load) begin
        miso_o <= rd_word[7];
        tx_shift <= rd_word[6:0];
      end else if (sclk_fall) begin
        miso_o <= tx_shift[6];
        tx_shift <= {tx_shift[5:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // chip level outputs
  wire powered = (state != SEQ_OFF);
  wire irq_any = |wake_flag;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      osc_en_o <= 1'b0;
      dreg_en_o <= 1'b0;
      clock_out_en_o <= 1'b0;
      clock_out_rate_o <= '0;
      radio_idle_o <= '0;
      group_clear_o <= 4'hF;
    end else begin
      irq_o <= powered & (irq_any ^ cfg[CFG_IRQ_POLARITY_BIT_BIT]);
      osc_en_o <= powered;
      dreg_en_o <= powered;
      clock_out_en_o <= powered & (clock_out_pin_cfg[CLOCK_OUT_PIN_RATE_MSB:0] != 3'h0);
      clock_out_rate_o <= clock_out_pin_cfg[CLOCK_OUT_PIN_RATE_MSB:0];
      radio_idle_o <= {2{seq_idle}} & ~trx_busy;
      group_clear_o[GRP_COMMON] <= clr_common;
      group_clear_o[GRP_IQ] <= clr_iq;
      group_clear_o[GRP_TRX0 +: 2] <= clr_trx;
    end
  end
endmodule
`default_nettype wire

/* drs_assertions.sv */
// checker: port-level properties of the dual radio reset sequencer
`default_nettype none
module drs_assertions #(
  parameter int RST_PULSE_CYCLES = 40
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic supply_ok_i,
  input wire logic ext_reset_n_i,
  input wire logic deep_sleep_i,
  input wire logic [1:0] trx_sleep_i,
  input wire logic miso_oe_n_o,
  input wire logic irq_o,
  input wire logic osc_en_o,
  input wire logic dreg_en_o,
  input wire logic clock_out_en_o,
  input wire logic [2:0] clock_out_rate_o,
  input wire logic [1:0] radio_idle_o,
  input wire logic [3:0] group_clear_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================================
  // reset pin low width, saturating so a stuck pin never wraps
  logic [7:0] low_cnt;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt <= 8'h00;
    end else if (ext_reset_n_i) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hFF) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  // ==========================================================
  // properties
  chk_pin_reset: assert property (
    $rose(ext_reset_n_i) && low_cnt >= RST_PULSE_CYCLES + 1 && radio_idle_o == 2'b11
    |-> ##[1:6] (radio_idle_o == 2'b00 && group_clear_o == 4'hF))
    else $error("long reset pulse did not enter reset");
  chk_pin_glitch: assert property (
    $rose(ext_reset_n_i) && low_cnt + 1 < RST_PULSE_CYCLES && radio_idle_o == 2'b11
    |-> ##1 (radio_idle_o == 2'b11) [*6])
    else $error("short reset pulse disturbed idle");
  chk_supply_off: assert property (
    $fell(supply_ok_i) |-> ##[1:5] (!osc_en_o && !dreg_en_o && radio_idle_o == 2'b00))
    else $error("supply loss did not power down");
  chk_clkout_default: assert property (
    $rose(osc_en_o) |-> ##[0:2] (clock_out_en_o && clock_out_rate_o == 3'h1))
    else $error("clock out not at default rate after power up");
  chk_clkout_osc: assert property (
    clock_out_en_o |-> osc_en_o && dreg_en_o)
    else $error("clock out without oscillator and regulator");
  chk_wake_irq: assert property (
    radio_idle_o == 2'b11 && $past(radio_idle_o) == 2'b00 |-> ##[0:2] irq_o)
    else $error("wake interrupt missing after full reset");
  chk_port_gate: assert property (
    !miso_oe_n_o |-> radio_idle_o != 2'b00)
    else $error("control port answered outside idle");
  chk_common_kept: assert property (
    radio_idle_o != 2'b00 |-> !group_clear_o[0])
    else $error("common group cleared while idle");
  chk_deep_clear: assert property (
    deep_sleep_i |=> group_clear_o[3:1] == 3'b111)
    else $error("deep sleep left a group uncleared");
  chk_trx_sleep: assert property (
    trx_sleep_i != 2'b00
    |=> (group_clear_o[3:2] & $past(trx_sleep_i)) == $past(trx_sleep_i))
    else $error("transceiver sleep did not clear its group");
endmodule
`default_nettype wire

/* drs_host_model.sv */
// partner: host microcontroller driving the reset pin and the control port
`default_nettype none
module drs_host_model (
  input wire logic mclk_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic seln_n_o,
  output logic mosi_o,
  output logic ext_reset_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 1'b0;
    seln_n_o = 1'b1;
    mosi_o = 1'b0;
    ext_reset_n_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // single access: two command bytes and one data byte, msb first, mode 0
  task automatic xfer(input logic [15:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd};
    tick(1);
    seln_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi_o = sh[i];
      tick(4);
      sclk_o = 1'b1;
      tick(4);
      // miso stands until the coming fall, so take it just before lowering sclk
      rd = {rd[6:0], miso_i};
      sclk_o = 1'b0;
    end
    tick(5);
    seln_n_o = 1'b1;
    // an idle line must not keep showing the last bit
    mosi_o = ~mosi_o;
    tick(2);
  endtask
  task automatic pulse(input int n);
    tick(1);
    ext_reset_n_o = 1'b0;
    tick(n);
    ext_reset_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

/* drs_tb.sv */
// testbench: reset, wake and register-group sequencing of the sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import drs_pkg::*;
  localparam int PULSE = 4;
  localparam logic [13:0] ST0 = 14'h0100;
  localparam logic [13:0] ST1 = 14'h0200;
  localparam logic [13:0] BK0 = 14'h0110;
  localparam logic [13:0] BK1 = 14'h0210;
  localparam logic [13:0] RC0 = 14'h0102;
  localparam logic [13:0] RC1 = 14'h0202;
  logic mclk, rst, supply_ok, ext_reset_n, sclk, seln_n, mosi, deep_sleep;
  logic miso, miso_oe_n, irq, osc_en, dreg_en, clk_en;
  logic [1:0] trx_sleep, radio_idle;
  logic [2:0] clk_rate;
  logic [3:0] group_clear;
  logic [7:0] iq_a, iq_b, rd;
  int error_cnt = 0;
  int checked = 0;

  drs_sequencer #(
    .RST_PULSE_CYCLES(PULSE),
    .POWERUP_CYCLES(8),
    .CHIP_RESET_CYCLES(30),
    .TRX_RESET_CYCLES(30)
  ) dut_u (
    .mclk_i(mclk), .rst_i(rst), .supply_ok_i(supply_ok), .ext_reset_n_i(ext_reset_n),
    .sclk_i(sclk), .seln_n_i(seln_n), .mosi_i(mosi), .deep_sleep_i(deep_sleep),
    .trx_sleep_i(trx_sleep), .miso_o(miso), .miso_oe_n_o(miso_oe_n), .irq_o(irq),
    .osc_en_o(osc_en), .dreg_en_o(dreg_en), .clock_out_en_o(clk_en),
    .clock_out_rate_o(clk_rate), .radio_idle_o(radio_idle), .group_clear_o(group_clear),
    .iq_link_config_a_o(iq_a), .iq_link_config_b_o(iq_b)
  );
  drs_host_model host_u (
    .mclk_i(mclk), .miso_i(miso), .sclk_o(sclk), .seln_n_o(seln_n), .mosi_o(mosi),
    .ext_reset_n_o(ext_reset_n)
  );

  // ==========================================================
  // helpers
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    host_u.xfer({2'b10, a}, d, rd);
  endtask
  task automatic chk_rd(input logic [13:0] a, input logic [7:0] e);
    host_u.xfer({2'b00, a}, 8'h00, rd);
    cmp($sformatf("reg %h", a), e, rd);
  endtask
  // the host holds off the port until the wake interrupt shows
  task automatic wait_irq();
    int n;
    n = 0;
    // look off the edge so the interrupt register has settled
    while (irq !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    cmp("irq", 8'h01, {7'h0, irq});
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog and test sequence
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    supply_ok = 1'b1;
    deep_sleep = 1'b0;
    trx_sleep = 2'b00;
    step(12);
    rst = 1'b0;
    wait_irq();
    cmp("osc dreg", 8'h03, {6'h0, osc_en, dreg_en});
    cmp("clock out", 8'h09, {4'h0, clk_en, clk_rate});
    chk_rd(ADDR_CFG, CFG_INIT);
    chk_rd(ADDR_CHIP_RESET, 8'h00);
    chk_rd(ST0, 8'h01);
    chk_rd(ST1, 8'h01);
    cmp("irq idle", 8'h00, {7'h0, irq});
    wr(ADDR_IQ_A, 8'h5A);
    wr(BK0, 8'hA5);
    wr(BK1, 8'h3C);
    for (int v = 0; v < 7; v++) begin
      wr(ADDR_CHIP_RESET, 8'(v) | 8'hF0);
      chk_rd(ADDR_CHIP_RESET, 8'(v));
      cmp("idle", 8'h03, {6'h0, radio_idle});
    end
    wr(ADDR_CLOCK_OUT_PIN, 8'h00);
    cmp("clock out off", 8'h00, {4'h0, clk_en, clk_rate});
    // transceiver reset of the sub-GHz side only
    wr(RC0, RADIO_CMD_RESET);
    cmp("idle trx", 8'h02, {6'h0, radio_idle});
    wait_irq();
    cmp("idle", 8'h03, {6'h0, radio_idle});
    chk_rd(ST1, 8'h00);
    chk_rd(ST0, 8'h01);
    chk_rd(BK0, BANK_INIT);
    chk_rd(BK1, 8'h3C);
    chk_rd(ADDR_IQ_A, 8'h5A);
    chk_rd(ADDR_CLOCK_OUT_PIN, 8'h00);
    // transceiver reset of the 2.4 GHz side only
    wr(RC1, RADIO_CMD_RESET);
    cmp("idle trx1", 8'h01, {6'h0, radio_idle});
    wait_irq();
    chk_rd(ST0, 8'h00);
    chk_rd(ST1, 8'h01);
    chk_rd(BK1, BANK_INIT);
    wr(BK1, 8'h3C);
    // chip reset by command
    wr(ADDR_CHIP_RESET, 8'h07);
    cmp("reset busy", 8'h0F, {2'h0, radio_idle, group_clear});
    wait_irq();
    cmp("idle", 8'h03, {6'h0, radio_idle});
    chk_rd(ADDR_IQ_A, IQ_INIT);
    cmp("iq a out", IQ_INIT, iq_a);
    chk_rd(BK1, BANK_INIT);
    chk_rd(ADDR_CLOCK_OUT_PIN, CLOCK_OUT_PIN_INIT);
    chk_rd(ST0, 8'h01);
    chk_rd(ST1, 8'h01);
    // polarity flipped, then restored by a pin reset
    wr(ADDR_CFG, CFG_INIT | 8'h04);
    cmp("irq inverted", 8'h01, {7'h0, irq});
    host_u.pulse(PULSE - 2);
    step(8);
    cmp("idle", 8'h03, {6'h0, radio_idle});
    host_u.pulse(PULSE + 2);
    step(6);
    cmp("pin reset", 8'h00, {6'h0, radio_idle});
    wait_irq();
    chk_rd(ADDR_CFG, CFG_INIT);
    // sleep group clears
    deep_sleep = 1'b1;
    step(2);
    cmp("deep sleep", 8'h0E, {4'h0, group_clear});
    deep_sleep = 1'b0;
    trx_sleep = 2'b10;
    step(2);
    cmp("sleep trx1", 8'h08, {4'h0, group_clear});
    trx_sleep = 2'b01;
    step(2);
    cmp("sleep trx0", 8'h04, {4'h0, group_clear});
    trx_sleep = 2'b00;
    // supply loss, with an access tried while powered down
    wr(ADDR_IQ_B, 8'h77);
    cmp("iq b out", 8'h77, iq_b);
    supply_ok = 1'b0;
    step(6);
    cmp("powered down", 8'h00, {6'h0, osc_en, dreg_en});
    wr(ADDR_IQ_A, 8'h33);
    supply_ok = 1'b1;
    wait_irq();
    chk_rd(ADDR_IQ_A, IQ_INIT);
    chk_rd(ADDR_IQ_B, IQ_INIT);
    cmp("iq b out", IQ_INIT, iq_b);
    final_report();
  end
endmodule

bind drs_sequencer drs_assertions #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) chk_u (
  .mclk_i(mclk_i), .rst_i(rst_i), .supply_ok_i(supply_ok_i), .ext_reset_n_i(ext_reset_n_i),
  .deep_sleep_i(deep_sleep_i), .trx_sleep_i(trx_sleep_i), .miso_oe_n_o(miso_oe_n_o),
  .irq_o(irq_o), .osc_en_o(osc_en_o), .dreg_en_o(dreg_en_o),
  .clock_out_en_o(clock_out_en_o), .clock_out_rate_o(clock_out_rate_o),
  .radio_idle_o(radio_idle_o), .group_clear_o(group_clear_o)
);
`default_nettype wire
